// File: hdl/black_level_calibration.sv
// dark-row generation, dark-level filtering and offset correction of the pixel stream
`timescale 1ns/1ps
`include "blc_defs.svh"
module black_level_calibration
   import blc_pkg::*;
#(
   parameter int ROW_W = 13,
   parameter logic [9:0] TARGET = 10'h000
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // register port
   input wire logic [8:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   // active window
   input wire logic [ROW_W-1:0] row_length_in,
   // pixel input
   input wire logic pix_valid_in,
   output logic pix_ready_out,
   input wire logic pix_sof_in,
   input wire logic [9:0] pix_data_in,
   // pixel output
   output logic pix_valid_out,
   input wire logic pix_ready_in,
   output logic pix_sof_out,
   output logic pix_dark_out,
   output logic [9:0] pix_data_out,
   // state
   output logic [7:0] active_rows_out,
   output logic frame_blank_out,
   output logic cal_error_out
);
   pix_if in_bus ();
   pix_if out_bus ();

   logic [15:0] sample_cfg_reg;
   logic [15:0] corr_cfg_reg;
   logic [15:0] rowgen_cfg_reg;
   logic [15:0] sync_cfg_reg;
   logic [15:0] rdata_reg;
   logic [7:0] active_rows_reg;
   logic blank_reg;
   logic err_reg;
   logic [ROW_W-1:0] col_reg;
   logic [7:0] row_reg;
   logic [7:0] cnt_reg;
   logic [16:0] sum_reg;
   logic [9:0] avg_reg;

   logic accept;
   logic sof;
   logic [7:0] rows_cfg;
   logic [7:0] rows_eff;
   logic blank_eff;
   logic [ROW_W-1:0] cur_col;
   logic [7:0] cur_row;
   logic [7:0] cur_cnt;
   logic [16:0] cur_sum;
   logic [16:0] sum_new;
   logic [2:0] exp_n;
   logic [8:0] need;
   logic dark;
   logic gated;
   logic push;
   logic samp;
   logic done;
   logic short_end;
   logic auto_en;
   logic frozen;
   logic [8:0] offs;
   logic [9:0] avg_new;
   logic signed [12:0] corr_val;
   logic [9:0] out_val;

   // register writes
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sample_cfg_reg <= `RST_SAMPLE_CFG;
         corr_cfg_reg <= `RST_CORR_CFG;
         rowgen_cfg_reg <= `RST_ROWGEN_CFG;
         sync_cfg_reg <= `RST_SYNC_CFG;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            `ADDR_SAMPLE_CFG: sample_cfg_reg <= reg_wdata_in;
            `ADDR_CORR_CFG: corr_cfg_reg <= reg_wdata_in;
            `ADDR_ROWGEN_CFG: rowgen_cfg_reg <= reg_wdata_in;
            `ADDR_SYNC_CFG: sync_cfg_reg <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // register reads, answered one cycle after the strobe
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_reg <= 16'h0000;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `ADDR_SAMPLE_CFG: rdata_reg <= sample_cfg_reg;
            `ADDR_CORR_CFG: rdata_reg <= corr_cfg_reg;
            `ADDR_ROWGEN_CFG: rdata_reg <= rowgen_cfg_reg;
            `ADDR_SYNC_CFG: rdata_reg <= sync_cfg_reg;
            `ADDR_STATUS: rdata_reg <= {15'h0000, err_reg};
            default: rdata_reg <= 16'h0000;
         endcase
      end
   end
   assign reg_rdata_out = rdata_reg;

   // frame position and configuration in effect for the current pixel
   assign accept = pix_valid_in && in_bus.ready;
   assign sof = accept && pix_sof_in;
   assign rows_cfg = (rowgen_cfg_reg[`ROWS_MSB:`ROWS_LSB] < `ROWS_MIN) ? `ROWS_MIN :
      (rowgen_cfg_reg[`ROWS_MSB:`ROWS_LSB] > `ROWS_MAX) ? `ROWS_MAX :
      rowgen_cfg_reg[`ROWS_MSB:`ROWS_LSB];
   assign rows_eff = (sof && sync_cfg_reg[`SYNC_ROWS_BIT]) ? rows_cfg : active_rows_reg;
   assign blank_eff = sof ? (rows_eff != active_rows_reg) : blank_reg;
   assign cur_col = sof ? '0 : col_reg;
   assign cur_row = sof ? 8'h00 : row_reg;
   assign cur_cnt = sof ? 8'h00 : cnt_reg;
   assign cur_sum = sof ? 17'h00000 : sum_reg;
   assign dark = cur_row < rows_eff;
   assign gated = dark && (rowgen_cfg_reg[`GATE_MSB:`GATE_LSB] != 2'b00)
      && (cur_row == 8'h00);
   assign push = accept && !gated && !blank_eff;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         active_rows_reg <= `RST_ACTIVE_ROWS;
         blank_reg <= 1'b0;
      end else if (sof) begin
         active_rows_reg <= rows_eff;
         blank_reg <= blank_eff;
      end
   end

   // row and column counters, a dark row spans one window row
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         col_reg <= '0;
         row_reg <= 8'h00;
      end else if (accept) begin
         if (cur_col + 1'b1 >= row_length_in) begin
            col_reg <= '0;
            row_reg <= (cur_row == 8'hFF) ? cur_row : cur_row + 8'h01;
         end else begin
            col_reg <= cur_col + 1'b1;
            row_reg <= cur_row;
         end
      end
   end

   // dark sample averaging
   assign exp_n = sample_cfg_reg[`SAMPLE_EXP_MSB:`SAMPLE_EXP_LSB];
   assign need = 9'h001 << exp_n;
   assign samp = accept && dark && !gated && ({1'b0, cur_cnt} < need);
   assign sum_new = cur_sum + {7'h00, pix_data_in};
   assign done = samp && ({1'b0, cur_cnt} + 9'h001 == need);
   assign avg_new = 10'(sum_new >> exp_n);
   assign short_end = accept && !dark && (cur_row == rows_eff) && (cur_col == '0)
      && ({1'b0, cur_cnt} < need);
   assign auto_en = corr_cfg_reg[`AUTO_EN_BIT];
   assign offs = corr_cfg_reg[`OFFS_MSB:`OFFS_LSB];
   assign frozen = auto_en && (offs == `FREEZE_CODE);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_reg <= 8'h00;
         sum_reg <= 17'h00000;
      end else if (samp) begin
         cnt_reg <= cur_cnt + 8'h01;
         sum_reg <= sum_new;
      end else if (sof) begin
         cnt_reg <= 8'h00;
         sum_reg <= 17'h00000;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         avg_reg <= 10'h000;
      end else if (done && auto_en && !frozen) begin
         avg_reg <= avg_new;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         err_reg <= 1'b0;
      end else if (short_end) begin
         err_reg <= 1'b1;
      end else if (done) begin
         err_reg <= 1'b0;
      end
   end

   // correction of image pixels
   always_comb begin
      if (auto_en) begin
         corr_val = $signed({3'b000, pix_data_in}) - $signed({3'b000, avg_reg})
            + $signed({3'b000, TARGET});
      end else if (corr_cfg_reg[`SIGN_BIT]) begin
         corr_val = $signed({3'b000, pix_data_in}) - $signed({4'b0000, offs});
      end else begin
         corr_val = $signed({3'b000, pix_data_in}) + $signed({4'b0000, offs});
      end
      if (corr_val < 0) begin
         out_val = 10'h000;
      end else if (corr_val > $signed(`PIX_MAX)) begin
         out_val = 10'h3FF;
      end else begin
         out_val = corr_val[9:0];
      end
   end

   assign in_bus.valid = push;
   assign in_bus.beat.sof = pix_sof_in;
   assign in_bus.beat.dark = dark;
   assign in_bus.beat.data = dark ? pix_data_in : out_val;
   assign pix_ready_out = in_bus.ready;

   pix_buffer #(
      .DEPTH(2)
   ) u_buffer (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .in_if(in_bus),
      .out_if(out_bus)
   );

   assign pix_valid_out = out_bus.valid;
   assign out_bus.ready = pix_ready_in;
   assign pix_sof_out = out_bus.beat.sof;
   assign pix_dark_out = out_bus.beat.dark;
   assign pix_data_out = out_bus.beat.data;
   assign active_rows_out = active_rows_reg;
   assign frame_blank_out = blank_reg;
   assign cal_error_out = err_reg;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   a_dark_raw_out: assert property (push && dark |-> in_bus.beat.data == pix_data_in)
      else $error("dark pixel altered");
   a_gate_first_row: assert property (gated |-> !push && !samp)
      else $error("skipped dark row used");
   a_rows_in_range: assert property (active_rows_reg >= `ROWS_MIN
      && active_rows_reg <= `ROWS_MAX)
      else $error("dark row count out of range");
   a_rows_sync_hold: assert property (!sync_cfg_reg[`SYNC_ROWS_BIT] |=> $stable(active_rows_reg))
      else $error("dark row count changed without sync");
   a_freeze_hold: assert property (frozen && $past(frozen) |-> $stable(avg_reg))
      else $error("frozen correction changed");
   a_recalc_frame: assert property (done && auto_en && !frozen |=> avg_reg == $past(avg_new))
      else $error("correction not recomputed");
   a_blank_drop: assert property (sof && active_rows_reg != rows_eff |=> blank_reg)
      else $error("row count change did not blank");
   a_short_error: assert property (short_end |=> err_reg && cal_error_out)
      else $error("missing sample error");
   a_manual_sub: assert property (push && !dark && !auto_en && corr_cfg_reg[`SIGN_BIT]
      && pix_data_in >= 10'(offs) |-> in_bus.beat.data == pix_data_in - 10'(offs))
      else $error("manual subtract wrong");
   a_manual_add: assert property (push && !dark && !auto_en && !corr_cfg_reg[`SIGN_BIT]
      && ({1'b0, pix_data_in} + {2'b00, offs}) <= 11'h3FF
      |-> in_bus.beat.data == pix_data_in + 10'(offs))
      else $error("manual add wrong");
   a_manual_sat: assert property (push && !dark && !auto_en && !corr_cfg_reg[`SIGN_BIT]
      && ({1'b0, pix_data_in} + {2'b00, offs}) > 11'h3FF |-> in_bus.beat.data == 10'h3FF)
      else $error("manual saturation wrong");
   a_auto_no_sign: assert property (push && !dark && auto_en && pix_data_in >= avg_reg
      && ({1'b0, pix_data_in} - {1'b0, avg_reg} + {1'b0, TARGET}) <= 11'h3FF
      |-> in_bus.beat.data == 10'(pix_data_in - avg_reg + TARGET))
      else $error("auto mode result wrong");
   a_blank_no_push: assert property (blank_reg && !sof |-> !push)
      else $error("blanked frame pushed a pixel");
   a_rows_only_sof: assert property (!sof |=> $stable(active_rows_reg))
      else $error("dark row count changed inside a frame");
   a_error_clear: assert property (done |=> !err_reg)
      else $error("error kept after full sample set");
endmodule : black_level_calibration

// File: hdl/blc_defs.svh
// register offsets, field positions, reset values and limits of the dark-level stage
`ifndef BLC_DEFS_SVH
`define BLC_DEFS_SVH

`define ADDR_SAMPLE_CFG 9'h080
`define ADDR_CORR_CFG 9'h081
`define ADDR_STATUS 9'h088
`define ADDR_ROWGEN_CFG 9'h0C5
`define ADDR_SYNC_CFG 9'h0CE

`define SAMPLE_EXP_MSB 10
`define SAMPLE_EXP_LSB 8
`define AUTO_EN_BIT 0
`define OFFS_MSB 9
`define OFFS_LSB 1
`define SIGN_BIT 10
`define ROWS_MSB 7
`define ROWS_LSB 0
`define GATE_MSB 9
`define GATE_LSB 8
`define SYNC_ROWS_BIT 1
`define ERR_BIT 0

`define RST_SAMPLE_CFG 16'h0300
`define RST_CORR_CFG 16'h0001
`define RST_ROWGEN_CFG 16'h0108
`define RST_SYNC_CFG 16'h0002
`define RST_ACTIVE_ROWS 8'h08

`define FREEZE_CODE 9'h1FF
`define ROWS_MIN 8'h01
`define ROWS_MAX 8'h7F
`define PIX_MAX 13'h03FF

`endif

// File: hdl/blc_pkg.sv
// types shared by the dark-level stage
package blc_pkg;
   typedef logic [9:0] pixel_t;
   typedef struct packed {
      logic sof;
      logic dark;
      pixel_t data;
   } pix_beat_t;
endpackage : blc_pkg

// File: hdl/pix_buffer.sv
// two-entry buffer for pixel beats
`timescale 1ns/1ps
module pix_buffer
   import blc_pkg::*;
#(
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // fill and drain sides
   pix_if.snk in_if,
   pix_if.src out_if
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   pix_beat_t mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_if.ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_if.valid = (cnt_reg != '0);
   assign out_if.beat = mem[rd_reg];
   assign push = in_if.valid && in_if.ready;
   assign pop = out_if.valid && out_if.ready;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_reg] <= in_if.beat;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_buf_bound: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cnt_reg <= (AW+1)'(DEPTH))
      else $error("buffer count above depth");
endmodule : pix_buffer

// File: hdl/pix_if.sv
// pixel beat carrier between the stage and its output buffer
`timescale 1ns/1ps
interface pix_if;
   import blc_pkg::*;
   pix_beat_t beat;
   logic valid;
   logic ready;
   modport src (output beat, output valid, input ready);
   modport snk (input beat, input valid, output ready);
endinterface : pix_if

// File: verification/tb_top.sv
// self-checking bench of the dark-level stage
`timescale 1ns/1ps
`include "blc_defs.svh"
module tb_top;
   import blc_pkg::*;
   logic clk_in = 1'h0;
   logic rstn_in = 1'h0;
   logic [8:0] reg_addr_in = 9'h000;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic reg_wr_in = 1'h0;
   logic reg_rd_in = 1'h0;
   logic [15:0] reg_rdata_out;
   logic [12:0] row_length_in = 13'h0004;
   logic pix_valid_in = 1'h0;
   logic pix_ready_out;
   logic pix_sof_in = 1'h0;
   logic [9:0] pix_data_in = 10'h000;
   logic pix_valid_out;
   logic pix_ready_in = 1'h1;
   logic pix_sof_out;
   logic pix_dark_out;
   logic [9:0] pix_data_out;
   logic [7:0] active_rows_out;
   logic frame_blank_out;
   logic cal_error_out;
   logic stall = 1'h0;
   logic rdy_s = 1'h0;
   logic full_seen = 1'h0;
   logic [1:0] cyc = 2'h0;
   logic [11:0] got_q[$];
   int bad_count = 0;
   int n_checks = 0;

   always #12.5 clk_in = ~clk_in;

   black_level_calibration u_dut (
      .clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
      .row_length_in, .pix_valid_in, .pix_ready_out, .pix_sof_in, .pix_data_in, .pix_valid_out,
      .pix_ready_in, .pix_sof_out, .pix_dark_out, .pix_data_out, .active_rows_out,
      .frame_blank_out, .cal_error_out
   );

   // ready as seen just before the next rising edge
   always @(negedge clk_in) begin
      rdy_s = pix_ready_out;
      if (pix_ready_out === 1'h0) full_seen = 1'h1;
   end

   // receiver with optional stall, collects delivered beats
   always @(posedge clk_in) begin
      cyc <= cyc + 2'h1;
      pix_ready_in <= !stall || (cyc == 2'h3);
      if (pix_valid_out && pix_ready_in) got_q.push_back({pix_sof_out, pix_dark_out, pix_data_out});
   end

   task test_done;
      if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   task chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'h1) begin
         bad_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk

   task wr(input logic [8:0] a, input logic [15:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'h1;
      @(posedge clk_in);
      reg_wr_in <= 1'h0;
      @(posedge clk_in);
   endtask : wr

   task rchk(input logic [8:0] a, input logic [15:0] x);
      reg_addr_in <= a;
      reg_rd_in <= 1'h1;
      @(posedge clk_in);
      reg_rd_in <= 1'h0;
      @(posedge clk_in);
      chk(reg_rdata_out === x, "register read");
   endtask : rchk

   task put(input logic s, input logic [9:0] d);
      pix_valid_in <= 1'h1;
      pix_sof_in <= s;
      pix_data_in <= d;
      do @(posedge clk_in); while (rdy_s !== 1'h1);
   endtask : put

   // md 0 compares the frame, 1 expects it blanked, 2 only sends it
   task frame(input int nr, nd, sk, md, input logic [9:0] d0, db, iv, eo);
      logic [9:0] v;
      logic [11:0] e;
      logic [11:0] g;
      got_q.delete();
      for (int r = 0; r < nr; r++) begin
         for (int c = 0; c < 4; c++) begin
            v = r < nd ? (r == 0 ? d0 : db) + 10'(c) : iv;
            put(r == 0 && c == 0, v);
         end
      end
      pix_valid_in <= 1'h0;
      if (md < 2) chk(frame_blank_out === (md == 1), "blank flag");
      repeat (40) @(posedge clk_in);
      if (md == 1) chk(got_q.size() == 0, "blanked frame has output");
      if (md == 0 && got_q.size() != (nr - sk) * 4) chk(1'h0, "beat count");
      else if (md == 0) begin
         for (int r = sk; r < nr; r++) begin
            for (int c = 0; c < 4; c++) begin
               v = r < nd ? (r == 0 ? d0 : db) + 10'(c) : eo;
               e = {r == 0 && c == 0, r < nd, v};
               g = got_q.pop_front();
               chk(g === e, "beat value");
            end
         end
      end
   endtask : frame

   task t_regs;
      chk(active_rows_out === `RST_ACTIVE_ROWS, "active rows at reset");
      rchk(`ADDR_SAMPLE_CFG, `RST_SAMPLE_CFG);
      rchk(`ADDR_CORR_CFG, `RST_CORR_CFG);
      rchk(`ADDR_ROWGEN_CFG, `RST_ROWGEN_CFG);
      rchk(`ADDR_SYNC_CFG, `RST_SYNC_CFG);
      rchk(9'h001, 16'h0000);
      wr(`ADDR_STATUS, 16'hFFFF);
      rchk(`ADDR_STATUS, 16'h0000);
   endtask : t_regs

   task t_manual;
      stall <= 1'h1;
      wr(`ADDR_ROWGEN_CFG, 16'h0002);
      wr(`ADDR_CORR_CFG, 16'h000A);
      frame(3, 2, 0, 1, 10'h028, 10'h050, 10'h064, 10'h000);
      chk(active_rows_out === 8'h02, "new row count");
      frame(3, 2, 0, 0, 10'h028, 10'h050, 10'h064, 10'h069);
      frame(3, 2, 0, 0, 10'h028, 10'h050, 10'h3FE, 10'h3FF);
      wr(`ADDR_CORR_CFG, 16'h040A);
      frame(3, 2, 0, 0, 10'h028, 10'h050, 10'h064, 10'h05F);
      chk(full_seen === 1'h1, "input never refused");
      stall <= 1'h0;
   endtask : t_manual

   task t_auto;
      wr(`ADDR_SAMPLE_CFG, 16'h0200);
      wr(`ADDR_CORR_CFG, 16'h0401);
      frame(3, 2, 0, 0, 10'h028, 10'h050, 10'h064, 10'h03B);
      wr(`ADDR_CORR_CFG, 16'h03FF);
      frame(3, 2, 0, 0, 10'h050, 10'h050, 10'h064, 10'h03B);
      wr(`ADDR_CORR_CFG, 16'h0001);
      frame(3, 2, 0, 0, 10'h050, 10'h050, 10'h064, 10'h013);
   endtask : t_auto

   task t_error;
      wr(`ADDR_SAMPLE_CFG, 16'h0400);
      frame(3, 2, 0, 2, 10'h028, 10'h028, 10'h064, 10'h000);
      chk(cal_error_out === 1'h1, "error not flagged");
      rchk(`ADDR_STATUS, 16'h0001);
      wr(`ADDR_SAMPLE_CFG, 16'h0200);
      frame(3, 2, 0, 2, 10'h028, 10'h028, 10'h064, 10'h000);
      chk(cal_error_out === 1'h0, "error not cleared");
   endtask : t_error

   task t_skip;
      wr(`ADDR_ROWGEN_CFG, 16'h0103);
      frame(4, 3, 1, 1, 10'h1F4, 10'h028, 10'h064, 10'h000);
      frame(4, 3, 1, 0, 10'h1F4, 10'h028, 10'h064, 10'h03B);
   endtask : t_skip

   task t_sync;
      wr(`ADDR_SYNC_CFG, 16'h0000);
      wr(`ADDR_ROWGEN_CFG, 16'h0105);
      frame(4, 3, 1, 0, 10'h1F4, 10'h028, 10'h064, 10'h03B);
      chk(active_rows_out === 8'h03, "count taken while sync off");
      wr(`ADDR_SYNC_CFG, 16'h0002);
      frame(1, 5, 0, 1, 10'h028, 10'h028, 10'h064, 10'h000);
      chk(active_rows_out === 8'h05, "count not taken");
      wr(`ADDR_ROWGEN_CFG, 16'h00FF);
      frame(1, 9, 0, 1, 10'h028, 10'h028, 10'h064, 10'h000);
      chk(active_rows_out === `ROWS_MAX, "count above maximum");
      wr(`ADDR_ROWGEN_CFG, 16'h0000);
      frame(1, 9, 0, 1, 10'h028, 10'h028, 10'h064, 10'h000);
      chk(active_rows_out === `ROWS_MIN, "count below minimum");
   endtask : t_sync

   task t_reset;
      rstn_in <= 1'h0;
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'h1;
      @(posedge clk_in);
      chk(frame_blank_out === 1'h0 && reg_rdata_out === 16'h0000, "state after reset");
      chk(active_rows_out === `RST_ACTIVE_ROWS, "rows after reset");
      rchk(`ADDR_ROWGEN_CFG, `RST_ROWGEN_CFG);
   endtask : t_reset

   initial begin
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'h1;
      @(posedge clk_in);
      t_regs();
      t_manual();
      t_auto();
      t_error();
      t_skip();
      t_sync();
      t_reset();
      test_done();
   end

   // watchdog, well beyond the roughly one thousand cycles the scenarios need
   initial begin
      repeat (20000) @(posedge clk_in);
      bad_count++;
      test_done();
   end
endmodule : tb_top
